// ===== testbench/tb.sv
// Self-checking bench for the controller and timer core pair.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb;
   import timer_pkg::*;
   logic        clk, reset, hsel, hwrite, hreadyout, hresp, gateEvent, pin, irq;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans;
   logic [15:0] seed;
   logic [7:0]  n, m;
   int          errors, compares, hi, irqs;
   timer_link_if timer_link_if_i ();
   pwm_timer_controller pwm_timer_controller_i (.clk(clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .gateEvent(gateEvent), .link(timer_link_if_i.controller));
   pwm_carrier_timer #(.CARRIER_CAPABLE(1'b1)) pwm_carrier_timer_i (.clk(clk), .reset(reset),
      .link(timer_link_if_i.device), .timerOutputPin(pin), .compareMatchIrq(irq));
   timer_link_chk timer_link_chk_i (.clk(clk), .reset(reset),
      .runEnable(timer_link_if_i.runEnable), .timerMode(timer_link_if_i.timerMode),
      .clockSelect(timer_link_if_i.clockSelect), .periodValue(timer_link_if_i.periodValue),
      .countTick(timer_link_if_i.countTick), .counterValue(timer_link_if_i.counterValue),
      .pendingGate(timer_link_if_i.pendingGate), .activeGate(timer_link_if_i.activeGate),
      .timerOutput(timer_link_if_i.timerOutput), .gateEvent(timer_link_if_i.gateEvent));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task tally_and_finish;
      if (errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // Waits for the edge where hready is high, bounded.
   task rdy;
      int k;
      k = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
         k++;
         if (k > 20) begin
            errors++;
            tally_and_finish();
         end
      end
   endtask : rdy
   // One single AHB-Lite transfer; read data lands in rdv.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rdv = hrdata;
   endtask : bus
   // Counts high pin cycles and match pulses over a window.
   task meas(input int c);
      hi = 0;
      irqs = 0;
      repeat (c) begin
         @(negedge clk);
         hi += int'(pin !== 1'b0);
         irqs += int'(irq !== 1'b0);
      end
   endtask : meas
   task pulse;
      gateEvent <= 1'b1;
      repeat (4) @(posedge clk);
      gateEvent <= 1'b0;
      repeat (20) @(posedge clk);
   endtask : pulse
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Reset, then a random and a corner PWM case, then the carrier.
   initial begin
      {reset, hsel, hwrite, haddr, htrans, hwdata, gateEvent} = {1'b1, 69'h0};
      {errors, compares, seed} = {64'h0, 16'hD00F};
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      bus(0, PERIOD_OFS, 0); `CHK(rdv, 32'h000000FF)
      bus(0, 8'h20, 0); `CHK(rdv, 32'h0)
      for (int i = 0; i < 2; i++) begin
         seed = lfsr(seed);
         n = i ? 8'h01 : {4'h0, seed[3:0]} | 8'h02;
         m = i ? 8'h00 : {4'h0, seed[11:8]} % n;
         bus(1, PERIOD_OFS, {24'h0, n});
         bus(1, WIDTH_OFS, {24'h0, m});
         bus(1, CTRL_OFS, {29'h0, MODE_PWM, 1'b1});
         repeat (3 * n + 8) @(posedge clk);
         meas(4 * (n + 1)); `CHK(hi, 4 * (m + 1))
         `CHK(irqs, 4)
         bus(1, WIDTH_OFS, {24'h0, n - 8'h01});
         repeat (3 * n + 8) @(posedge clk);
         meas(4 * (n + 1)); `CHK(hi, 4 * n)
         bus(1, CTRL_OFS, 32'h0);
         repeat (3) @(posedge clk);
         bus(0, STATUS_OFS, 0); `CHK(rdv, 32'h0)
      end
      bus(1, PERIOD_OFS, 32'h5);
      bus(1, WIDTH_OFS, 32'h2);
      bus(1, GATE_OFS, 32'h1);
      bus(1, CTRL_OFS, {25'h0, 1'b1, 3'h0, MODE_CARRIER, 1'b1});
      pulse();
      bus(0, GATE_OFS, 0); `CHK(rdv, 32'h7)
      meas(36); `CHK(hi, 12)
      `CHK(irqs, 8)
      bus(1, GATE_OFS, 32'h4);
      @(posedge clk);
      bus(0, GATE_OFS, 0); `CHK(rdv, 32'h2)
      pulse();
      meas(18); `CHK(hi, 0)
      tally_and_finish();
   end
endmodule : tb

// ===== testbench/timer_link_chk.sv
// Checker watching the link between the timer controller and the timer core.
`timescale 1ns/100ps
module timer_link_chk
   import timer_pkg::*;
(
   input wire logic             clk,
   input wire logic             reset,
   input wire logic             runEnable,
   input wire logic [1:0]       timerMode,
   input wire logic [CKS_W-1:0] clockSelect,
   input wire logic [CNT_W-1:0] periodValue,
   input wire logic             countTick,
   input wire logic [CNT_W-1:0] counterValue,
   input wire logic             pendingGate,
   input wire logic             activeGate,
   input wire logic             timerOutput,
   input wire logic             gateEvent
);
   // ****************************************************************
   // Timing relations on the link
   // ****************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // A gate event followed by a quiet pending bit on a full rate count clock.
   sequence gateWait;
      $rose(gateEvent) && clockSelect == 3'h0 ##0 $stable(pendingGate) [*8];
   endsequence
   sequence pwmRun;
      timerMode == MODE_PWM && runEnable && $past(runEnable);
   endsequence
   a_reset_idle: assert property (disable iff (1'b0) reset |=> counterValue == 8'h00
      && !activeGate && !timerOutput) else $error("state not idle after reset");
   a_stop_idle: assert property (!runEnable [*3] |-> counterValue == 8'h00 && !timerOutput)
      else $error("stopped timer not idle");
   a_first_mask: assert property ($rose(runEnable) && clockSelect == 3'h0 &&
      timerMode == MODE_PWM |=> counterValue == 8'h00 && !timerOutput) else $error("no mask");
   a_count_step: assert property (pwmRun ##0 $changed(counterValue) |->
      counterValue == $past(counterValue) + 8'h01 || counterValue == 8'h00) else $error("step");
   a_count_bound: assert property (pwmRun |-> counterValue <= periodValue)
      else $error("counter above period");
   a_period_clear: assert property (pwmRun ##0 countTick && counterValue == periodValue
      && counterValue != 8'h00 |=> counterValue == 8'h00 ##[0:2] timerOutput) else $error("clear");
   a_gate_copy: assert property (!$past(reset) && $changed(activeGate) |->
      activeGate == $past(pendingGate)) else $error("active gate not from pending");
   a_gate_delay: assert property (gateWait |-> activeGate == pendingGate)
      else $error("gate transfer late");
endmodule : timer_link_chk

// ===== verilog/count_clock_divider.sv
// Prescaler that turns the system clock into a count clock enable pulse.
`timescale 1ns/100ps
module count_clock_divider #(
   parameter int SEL_W = 3
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [SEL_W-1:0] clockSelect,
   output logic                  tick
);
   import timer_pkg::*;

   localparam int PRE_W = (1 << SEL_W) - 1;

   logic [PRE_W-1:0] prescale_q;
   logic [PRE_W-1:0] mask;

   // ****************************************************************
   // Free running prescaler
   // ****************************************************************

   // The prescaler never stops, so the count clock phase is independent of the run bit.
   always_ff @(posedge clk) begin
      if (reset) begin
         prescale_q <= '0;
      end else begin
         prescale_q <= prescale_q + 1'b1;
      end
   end

   // Division is by two to the power of the select value; select zero ticks every cycle.
   always_comb begin
      mask = PRE_W'((PRE_W+1)'(1) << clockSelect) - 1'b1;
      tick = ((prescale_q & mask) == mask);
   end

endmodule : count_clock_divider

// ===== verilog/pwm_carrier_timer.sv
// Eight bit compare timer with PWM and infrared carrier output modes.
`timescale 1ns/100ps

// What this block does
// R01 - Run bit starts counting; period register compared first.
// R02 - Period match clears, interrupts, drives active, swaps.
// R03 - Width match drives inactive, swaps back, no clear.
// R04 - PWM period N+1 ticks, active M+1 ticks.
// R05 - Software keeps width below period, within range.
// R06 - Width writes latched, applied at old match after three.
// R07 - Software rewrites width on every restart.
// R08 - First count tick after enable is masked.
// R09 - Stopping clears interrupt and level; plain gate carrier output keeps following active gate.
// R10 - Carrier mode: low width then high width.
// R11 - Low width register not rewritten while running.
// R12 - Remote enable and active gate select carrier output.
// R13 - Pending gate writable, active gate read only.
// R14 - Gate event synchronised; transfer on second tick.
// R15 - Pending gate writes spaced at least two ticks.
// R16 - Software reloads pending gate after each event.
// R17 - Transfer strobe stays internal, never an interrupt.
// R18 - Carrier match inverts, interrupts, clears, swaps target.
// R19 - Carrier period N+M+2 ticks, high M+1 ticks.
// R20 - Gate falling never truncates a high carrier pulse.
// R21 - Target returns to first register when stopped.
// R22 - Reset leaves everything inactive and stopped.
module pwm_carrier_timer #(
   parameter bit CARRIER_CAPABLE = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        reset,
   timer_link_if.device     link,
   output logic             timerOutputPin,
   output logic             compareMatchIrq
);
   import timer_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic             tick, countTick;
   logic             maskTick_q;
   logic [CNT_W-1:0] counter_q;
   target_type       target_q;
   logic             level_q, carrierHold_q, irq_q;
   logic             outPin_q, outPin_d;
   logic [CNT_W-1:0] widthActive_q, widthLatch_q;
   logic             latchFull_q;
   logic [1:0]       latchAge_q;
   logic             gateSync1_q, gateSync2_q, gateSync3_q;
   logic             transferStrobe;
   logic [1:0]       xferDelay_q;
   logic             pendingGate_q, activeGate_q;
   logic             carrierMode, pwmMode;
   logic             matchFirst, matchSecond, clearMatch;

   // ****************************************************************
   // Count clock and mode decode
   // ****************************************************************
   // The prescaler gives one enable pulse per count clock.
   count_clock_divider #(
      .SEL_W       (CKS_W)
   ) divider (
      .clk         (clk),
      .reset       (reset),
      .clockSelect (link.clockSelect),
      .tick        (tick)
   );

   // Carrier mode exists only on an instance built with it.
   assign carrierMode = CARRIER_CAPABLE && (link.timerMode == MODE_CARRIER); // R10
   assign pwmMode     = (link.timerMode == MODE_PWM);

   // Counting advances on ticks once running and past the masked first tick.
   assign countTick = tick && link.runEnable && !maskTick_q && (carrierMode || pwmMode); // R01

   // Compare against the register the target selector names.
   assign matchFirst  = (target_q == TARGET_FIRST) && (counter_q == link.periodValue);
   assign matchSecond = (target_q == TARGET_SECOND) && (counter_q == widthActive_q);
   assign clearMatch  = matchFirst || (matchSecond && carrierMode);

   // ****************************************************************
   // Start masking
   // ****************************************************************
   // The first count clock after enabling is swallowed before the counter moves.
   always_ff @(posedge clk) begin
      if (reset || !link.runEnable) begin
         maskTick_q <= 1'b1;
      end else if (tick) begin
         maskTick_q <= 1'b0; // R08
      end
   end

   // ****************************************************************
   // Counter and compare target
   // ****************************************************************
   // The counter clears on a period match, or on any match in carrier mode.
   always_ff @(posedge clk) begin
      if (reset || !link.runEnable) begin
         counter_q <= COUNT_RESET; // R22
      end else if (countTick) begin
         if (clearMatch) begin
            counter_q <= COUNT_RESET; // R02 R18
         end else begin
            counter_q <= counter_q + 1'b1; // R03 R04
         end
      end
   end

   // The target alternates between the two registers on each match.
   always_ff @(posedge clk) begin
      if (reset || !link.runEnable) begin
         target_q <= TARGET_FIRST; // R21 R01
      end else if (countTick) begin
         case (target_q)
            TARGET_FIRST: begin
               if (matchFirst) begin
                  target_q <= TARGET_SECOND; // R02
               end
            end
            TARGET_SECOND: begin
               if (matchSecond) begin
                  target_q <= TARGET_FIRST; // R03 R18
               end
            end
            default: begin
               target_q <= TARGET_FIRST;
            end
         endcase
      end
   end

   // ****************************************************************
   // Output level, carrier clock and interrupt
   // ****************************************************************
   // One flop serves as PWM level and as carrier clock: high after the first match.
   always_ff @(posedge clk) begin
      if (reset || !link.runEnable) begin
         level_q <= 1'b0; // R09
      end else if (countTick && matchFirst) begin
         level_q <= 1'b1; // R02 R18 R19
      end else if (countTick && matchSecond) begin
         level_q <= 1'b0; // R03 R18 R19
      end
   end

   // The match pulse lasts one system clock and returns low when stopped.
   always_ff @(posedge clk) begin
      irq_q <= !reset && countTick && clearMatch; // R02 R09 R18
   end

   // Carrier pulses are admitted only at a carrier rising edge and kept to its end.
   always_ff @(posedge clk) begin
      if (reset || !link.runEnable) begin
         carrierHold_q <= 1'b0;
      end else if (countTick && matchFirst) begin
         carrierHold_q <= activeGate_q; // R12
      end else if (countTick && matchSecond) begin
         carrierHold_q <= 1'b0; // R20
      end
   end

   // ****************************************************************
   // Deferred width update
   // ****************************************************************
   // A write while running waits in a latch until the old width matches and it has aged.
   always_ff @(posedge clk) begin
      if (reset) begin
         widthActive_q <= WIDTH_RESET;
         widthLatch_q  <= WIDTH_RESET;
         latchFull_q   <= 1'b0;
         latchAge_q    <= 2'h0;
      end else if (link.widthWrite) begin
         widthLatch_q <= link.widthValue;
         latchAge_q   <= 2'h0;
         if (!link.runEnable) begin
            widthActive_q <= link.widthValue;
            latchFull_q   <= 1'b0;
         end else begin
            latchFull_q <= 1'b1; // R06
         end
      end else begin
         if (tick && latchFull_q && (latchAge_q < WIDTH_AGE_TICKS)) begin
            latchAge_q <= latchAge_q + 1'b1;
         end
         if (countTick && matchSecond && latchFull_q && (latchAge_q >= WIDTH_AGE_TICKS)) begin
            widthActive_q <= widthLatch_q; // R06
            latchFull_q   <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Gate event synchroniser and master-slave gate bits
   // ****************************************************************
   // The event is sampled on count ticks; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      if (reset) begin
         gateSync1_q <= 1'b0;
         gateSync2_q <= 1'b0;
         gateSync3_q <= 1'b0;
      end else if (tick) begin
         gateSync1_q <= link.gateEvent; // R14
         gateSync2_q <= gateSync1_q;
         gateSync3_q <= gateSync2_q;
      end
   end

   // The strobe is used only for the transfer below and leaves no port.
   assign transferStrobe = gateSync2_q && !gateSync3_q; // R17

   // The pending bit moves to the active bit on the third tick after the strobe rises.
   always_ff @(posedge clk) begin
      if (reset) begin
         xferDelay_q  <= 2'h0;
         activeGate_q <= 1'b0; // R22
      end else if (tick) begin
         if (transferStrobe) begin
            xferDelay_q <= GATE_XFER_TICKS; // R14
         end else if (xferDelay_q != 2'h0) begin
            xferDelay_q <= xferDelay_q - 1'b1;
            if (xferDelay_q == 2'h1) begin
               activeGate_q <= pendingGate_q; // R13 R14
            end
         end
      end
   end

   // Software owns the pending bit directly.
   always_ff @(posedge clk) begin
      if (reset) begin
         pendingGate_q <= 1'b0;
      end else if (link.pendingWrite) begin
         pendingGate_q <= link.pendingValue; // R13
      end
   end

   // ****************************************************************
   // Pin selection
   // ****************************************************************
   // PWM shows the level; carrier shows plain gate or gated pulses.
   always_comb begin
      outPin_d = 1'b0;
      if (carrierMode) begin
         if (link.remoteEnable) begin
            outPin_d = level_q && carrierHold_q; // R12 R20
         end else begin
            outPin_d = activeGate_q; // R12
         end
      end else if (pwmMode) begin
         outPin_d = level_q; // R09
      end
   end

   // The pin is registered so it never glitches between modes.
   always_ff @(posedge clk) begin
      outPin_q <= !reset && outPin_d; // R22
   end
   // Pins and link status.
   assign timerOutputPin    = outPin_q;
   assign compareMatchIrq   = irq_q;
   assign link.counterValue = counter_q;
   assign link.pendingGate  = pendingGate_q;
   assign link.activeGate   = activeGate_q;
   assign link.timerOutput  = outPin_q;
   assign link.countTick    = tick;

endmodule : pwm_carrier_timer

// ===== verilog/pwm_timer_controller.sv
// AHB-Lite register controller that programs the timer over the link.
`timescale 1ns/100ps
module pwm_timer_controller (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        gateEvent,
   timer_link_if.controller link
);
   import timer_pkg::*;

   logic             take;
   logic             wrPend_q;
   logic [7:0]       wrAddr_q;
   logic [31:0]      rdata_q;
   logic             ctrlRun_q;
   logic             runOut_q;
   logic [1:0]       mode_q;
   logic [CKS_W-1:0] cks_q;
   logic             remote_q;
   logic [CNT_W-1:0] period_q;
   logic [CNT_W-1:0] width_q;
   logic             widthWrite_q;
   logic             pendWrite_q;
   logic             pendValue_q;
   logic [1:0]       gateGap_q;
   logic             gateSeen_q;
   logic             gatePrev_q;
   logic             wrCtrl, wrGate;

   // Read multiplexer shared by the address phase capture.
   function automatic logic [31:0] readWord(input logic [7:0] ofs);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (ofs)
         CTRL_OFS: begin
            w[CTRL_RUN_BIT]          = ctrlRun_q;
            w[CTRL_MODE_LSB +: 2]    = mode_q;
            w[CTRL_CKS_LSB +: CKS_W] = cks_q;
            w[CTRL_REMOTE_BIT]       = remote_q;
         end
         PERIOD_OFS: w[CNT_W-1:0] = period_q;
         WIDTH_OFS:  w[CNT_W-1:0] = width_q;
         GATE_OFS: begin
            w[GATE_PEND_BIT] = link.pendingGate;
            w[GATE_ACT_BIT]  = link.activeGate;
            w[GATE_SEEN_BIT] = gateSeen_q;
         end
         STATUS_OFS: begin
            w[STAT_OUT_BIT]          = link.timerOutput;
            w[STAT_RUN_BIT]          = runOut_q;
            w[STAT_CNT_LSB +: CNT_W] = link.counterValue;
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : readWord

   // ****************************************************************
   // Bus slave
   // ****************************************************************

   // Zero wait state slave; size is ignored as only whole words are used.
   assign take      = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   assign wrCtrl    = wrPend_q && (wrAddr_q == CTRL_OFS);
   assign wrGate    = wrPend_q && (wrAddr_q == GATE_OFS);

   // Address phase is captured; read data is fetched for the following data phase.
   always_ff @(posedge clk) begin
      if (reset) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         rdata_q  <= 32'h0000_0000;
      end else begin
         wrPend_q <= take && hwrite;
         if (take) begin
            wrAddr_q <= haddr[7:0];
         end
         if (take && !hwrite) begin
            rdata_q <= readWord(haddr[7:0]);
         end
      end
   end

   // ****************************************************************
   // Control and compare registers
   // ****************************************************************

   // Mode and clock may be changed only while stopped; remote bit likewise.
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrlRun_q <= 1'b0;
         mode_q    <= MODE_INTERVAL;
         cks_q     <= '0;
         remote_q  <= 1'b0;
      end else if (wrCtrl) begin
         ctrlRun_q <= hwdata[CTRL_RUN_BIT];
         if (!ctrlRun_q) begin
            mode_q   <= hwdata[CTRL_MODE_LSB +: 2];
            cks_q    <= hwdata[CTRL_CKS_LSB +: CKS_W];
            remote_q <= hwdata[CTRL_REMOTE_BIT];
         end
      end
   end

   // Run reaches the timer one cycle late so the width reload lands while stopped.
   always_ff @(posedge clk) begin
      if (reset) begin
         runOut_q <= 1'b0;
      end else begin
         runOut_q <= ctrlRun_q;
      end
   end

   // Period writes are dropped while running; widths at or above the period are dropped.
   always_ff @(posedge clk) begin
      if (reset) begin
         period_q     <= PERIOD_RESET;
         width_q      <= WIDTH_RESET;
         widthWrite_q <= 1'b0;
      end else begin
         widthWrite_q <= 1'b0;
         if (wrPend_q && (wrAddr_q == PERIOD_OFS) && !ctrlRun_q) begin
            period_q <= hwdata[CNT_W-1:0]; // R11
         end
         if (wrPend_q && (wrAddr_q == WIDTH_OFS) && (hwdata[CNT_W-1:0] < period_q)) begin
            width_q      <= hwdata[CNT_W-1:0]; // R05
            widthWrite_q <= 1'b1;
         end
         if (wrCtrl && hwdata[CTRL_RUN_BIT] && !ctrlRun_q) begin
            widthWrite_q <= 1'b1; // R07
         end
      end
   end

   // ****************************************************************
   // Gate bits and gate event flag
   // ****************************************************************

   // Pending gate writes closer than two count ticks apart are refused.
   always_ff @(posedge clk) begin
      if (reset) begin
         pendWrite_q <= 1'b0;
         pendValue_q <= 1'b0;
         gateGap_q   <= 2'h0;
      end else begin
         pendWrite_q <= 1'b0;
         if (wrGate && (gateGap_q == 2'h0)) begin
            pendWrite_q <= 1'b1; // R15
            pendValue_q <= hwdata[GATE_PEND_BIT];
            gateGap_q   <= GATE_WRITE_GAP;
         end else if (link.countTick && (gateGap_q != 2'h0)) begin
            gateGap_q <= gateGap_q - 1'b1;
         end
      end
   end

   // Sticky event flag for polling; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (reset) begin
         gatePrev_q <= 1'b0;
         gateSeen_q <= 1'b0;
      end else begin
         gatePrev_q <= gateEvent;
         if (gateEvent && !gatePrev_q) begin
            gateSeen_q <= 1'b1; // R16
         end else if (wrGate && hwdata[GATE_SEEN_BIT]) begin
            gateSeen_q <= 1'b0;
         end
      end
   end

   assign link.runEnable    = runOut_q;
   assign link.timerMode    = mode_q;
   assign link.clockSelect  = cks_q;
   assign link.remoteEnable = remote_q;
   assign link.periodValue  = period_q;
   assign link.widthValue   = width_q;
   assign link.widthWrite   = widthWrite_q;
   assign link.pendingValue = pendValue_q;
   assign link.pendingWrite = pendWrite_q;
   assign link.gateEvent    = gateEvent;

endmodule : pwm_timer_controller

// ===== verilog/timer_link_if.sv
// Interface joining the timer core and its register controller.
`timescale 1ns/100ps
interface timer_link_if;
   import timer_pkg::*;

   logic              runEnable;
   logic [1:0]        timerMode;
   logic [CKS_W-1:0]  clockSelect;
   logic              remoteEnable;
   logic [CNT_W-1:0]  periodValue;
   logic [CNT_W-1:0]  widthValue;
   logic              widthWrite;
   logic              pendingValue;
   logic              pendingWrite;
   logic              gateEvent;
   logic [CNT_W-1:0]  counterValue;
   logic              pendingGate;
   logic              activeGate;
   logic              timerOutput;
   logic              countTick;

   modport device (
      input  runEnable, timerMode, clockSelect, remoteEnable, periodValue, widthValue,
      input  widthWrite, pendingValue, pendingWrite, gateEvent,
      output counterValue, pendingGate, activeGate, timerOutput, countTick
   );

   modport controller (
      output runEnable, timerMode, clockSelect, remoteEnable, periodValue, widthValue,
      output widthWrite, pendingValue, pendingWrite, gateEvent,
      input  counterValue, pendingGate, activeGate, timerOutput, countTick
   );

endinterface : timer_link_if

// ===== verilog/timer_pkg.sv
// Shared constants, register map and types for the PWM and carrier timer pair.
package timer_pkg;

   // ****************************************************************
   // Widths and modes
   // ****************************************************************
   localparam int         CNT_W          = 8;
   localparam int         CKS_W          = 3;
   localparam logic [1:0] MODE_INTERVAL  = 2'h0;
   localparam logic [1:0] MODE_CARRIER   = 2'h1;
   localparam logic [1:0] MODE_PWM       = 2'h2;
   localparam logic [7:0] COUNT_RESET    = 8'h00;

   // ****************************************************************
   // Register offsets on the AHB-Lite side
   // ****************************************************************
   localparam logic [7:0] CTRL_OFS       = 8'h00;
   localparam logic [7:0] PERIOD_OFS     = 8'h04;
   localparam logic [7:0] WIDTH_OFS      = 8'h08;
   localparam logic [7:0] GATE_OFS       = 8'h0C;
   localparam logic [7:0] STATUS_OFS     = 8'h10;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int         CTRL_RUN_BIT   = 0;
   localparam int         CTRL_MODE_LSB  = 1;
   localparam int         CTRL_CKS_LSB   = 3;
   localparam int         CTRL_REMOTE_BIT = 6;
   localparam int         GATE_PEND_BIT  = 0;
   localparam int         GATE_ACT_BIT   = 1;
   localparam int         GATE_SEEN_BIT  = 2;
   localparam int         STAT_OUT_BIT   = 0;
   localparam int         STAT_RUN_BIT   = 1;
   localparam int         STAT_CNT_LSB   = 8;
   localparam logic [7:0] PERIOD_RESET   = 8'hFF;
   localparam logic [7:0] WIDTH_RESET    = 8'h00;

   // ****************************************************************
   // Timing counts in count clock ticks
   // ****************************************************************
   localparam logic [1:0] WIDTH_AGE_TICKS = 2'h3;
   localparam logic [1:0] GATE_XFER_TICKS = 2'h2;
   localparam logic [1:0] GATE_WRITE_GAP  = 2'h2;

   // Which compare register the counter is currently matched against.
   typedef enum logic [1:0] {
      TARGET_FIRST  = 2'b01,
      TARGET_SECOND = 2'b10
   } target_type;

endpackage : timer_pkg
